// >>> hdl/ubc_break.sv
// Design decisions made here: the register addresses and the APB interface to the registers.
module ubc_break (
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [ubc_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  input  wire ubc_pkg::ubc_cycle_s        bus_cycle,
  output logic                            break_req,
  output logic                            match_trigger_out_n,
  output logic                            irq
);
  import ubc_pkg::*;

  initial begin
    if (ADDR_W != 8) begin
      $error("ubc_break needs an 8-bit APB address");
    end
  end

  ubc_state_s q;
  ubc_state_s d;
  logic       hit_now;
  logic       size_ok;
  logic       addr_ok;
  logic       wr_en;
  logic [1:0] eff_size;
  logic [1:0] set_ev;
  logic [1:0] clr_ev;
  logic [1:0] src_sel;
  logic [1:0] kind_sel;
  logic [1:0] dir_sel;
  logic [1:0] size_sel;
  logic [1:0] wid_sel;
  logic [31:0] bar;
  logic [31:0] bmask;

  // ****************************************
  // Helpers
  // ****************************************
  // Two-bit select: 00 never, bit0 takes a, bit1 takes b
  function automatic logic field_ok(input logic [1:0] sel, input logic a, input logic b);
    field_ok = (sel[0] & a) | (sel[1] & b);
  endfunction

  function automatic logic [4:0] trig_width(input logic [1:0] code);
    logic [4:0] w;
    w = TRIG_W0;
    case (code)
      2'h1: w = TRIG_W1;
      2'h2: w = TRIG_W2;
      2'h3: w = TRIG_W3;
      default: w = TRIG_W0;
    endcase
    trig_width = w;
  endfunction

  function automatic logic addr_known(input logic [ADDR_W-1:0] a);
    addr_known = (a == OFS_BAR_HI) || (a == OFS_BAR_LO) || (a == OFS_MASK_HI) ||
                 (a == OFS_MASK_LO) || (a == OFS_CYCLE) || (a == OFS_CTRL) ||
                 (a == OFS_IRQ_STAT) || (a == OFS_IRQ_MASK);
  endfunction

  function automatic logic [31:0] read_word(input logic [ADDR_W-1:0] a, input ubc_state_s s);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == OFS_BAR_HI) begin
      r = {16'h0000, s.bar_hi};
    end else if (a == OFS_BAR_LO) begin
      r = {16'h0000, s.bar_lo};
    end else if (a == OFS_MASK_HI) begin
      r = {16'h0000, s.mask_hi};
    end else if (a == OFS_MASK_LO) begin
      r = {16'h0000, s.mask_lo};
    end else if (a == OFS_CYCLE) begin
      r = {24'h00_0000, s.cyc};
    end else if (a == OFS_CTRL) begin
      r = {29'h0000_0000, s.ctrl};
    end else if (a == OFS_IRQ_STAT) begin
      r = {30'h0000_0000, s.stat};
    end else if (a == OFS_IRQ_MASK) begin
      r = {30'h0000_0000, s.imask};
    end
    read_word = r;
  endfunction

  // ****************************************
  // Condition match
  // ****************************************
  assign src_sel  = q.cyc[CYC_SRC_LSB+1:CYC_SRC_LSB];
  assign kind_sel = q.cyc[CYC_KIND_LSB+1:CYC_KIND_LSB];
  assign dir_sel  = q.cyc[CYC_DIR_LSB+1:CYC_DIR_LSB];
  assign size_sel = q.cyc[CYC_SIZE_LSB+1:CYC_SIZE_LSB];
  assign wid_sel  = q.ctrl[CTRL_WID_LSB+1:CTRL_WID_LSB];
  assign bar      = {q.bar_hi, q.bar_lo};
  assign bmask    = {q.mask_hi, q.mask_lo};

  // Fetches always count as word; data uses requested size
  assign eff_size = bus_cycle.is_fetch ? SZ_WORD : bus_cycle.size;
  assign size_ok  = (size_sel == SZ_ANY) || (size_sel == eff_size);
  assign addr_ok  = ((bus_cycle.addr ^ bar) & ~bmask) == 32'h0000_0000;

  // Zero selects in any of three groups block the match
  assign hit_now = bus_cycle.valid && addr_ok && size_ok &&
                   field_ok(src_sel, !bus_cycle.is_dtc, bus_cycle.is_dtc) &&
                   field_ok(kind_sel, bus_cycle.is_fetch, !bus_cycle.is_fetch) &&
                   field_ok(dir_sel, !bus_cycle.is_write, bus_cycle.is_write);

  // ****************************************
  // APB slave
  // ****************************************
  assign pready  = psel & penable;
  assign pslverr = psel & penable & !addr_known(paddr);
  assign wr_en   = psel & penable & pwrite & addr_known(paddr);
  assign prdata  = q.rdata;

  assign set_ev = {hit_now & !q.ctrl[CTRL_DIS_BIT], hit_now};
  assign clr_ev = (wr_en && paddr == OFS_IRQ_STAT) ? pwdata[1:0] : 2'h0;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    d     = q;
    d.hit = 1'b0;
    d.req = 1'b0;
    if (hit_now) begin
      d.hit      = 1'b1;
      d.req      = !q.ctrl[CTRL_DIS_BIT];
      d.trig_cnt = trig_width(wid_sel);
    end else if (q.trig_cnt != 5'h00) begin
      d.trig_cnt = q.trig_cnt - 5'h01;
    end
    d.trig_n = (d.trig_cnt == 5'h00);
    if (psel && !penable && !pwrite) begin
      d.rdata = read_word(paddr, q);
    end
    if (wr_en) begin
      if (paddr == OFS_BAR_HI) begin
        d.bar_hi = pwdata[15:0];
      end else if (paddr == OFS_BAR_LO) begin
        d.bar_lo = pwdata[15:0];
      end else if (paddr == OFS_MASK_HI) begin
        d.mask_hi = pwdata[15:0];
      end else if (paddr == OFS_MASK_LO) begin
        d.mask_lo = pwdata[15:0];
      end else if (paddr == OFS_CYCLE) begin
        d.cyc = pwdata[7:0];
      end else if (paddr == OFS_CTRL) begin
        d.ctrl = pwdata[2:0];
      end else if (paddr == OFS_IRQ_MASK) begin
        d.imask = pwdata[1:0];
      end
    end
    // Set wins over a same-cycle write-one clear
    d.stat = (q.stat & ~clr_ev) | set_ev;
    d.irq  = |(d.stat & d.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= ST_RESET;
    end else begin
      q <= d;
    end
  end

  assign break_req           = q.req;
  assign match_trigger_out_n = q.trig_n;
  assign irq                 = q.irq;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic all_on;
  logic addr_miss;
  assign all_on    = (q.cyc[7:2] == 6'h3F) && (size_sel == SZ_ANY);
  assign addr_miss = ((bus_cycle.addr ^ bar) & ~bmask) != 32'h0000_0000;

  sequence quiet4_s;
    (!q.hit)[*4];
  endsequence

  sequence quiet1_s;
    !q.hit;
  endsequence

  off_group_a : assert property (
    bus_cycle.valid && (src_sel == 2'h0 || kind_sel == 2'h0 || dir_sel == 2'h0)
    |=> !q.hit && !break_req)
    else $error("break raised with a group set to 00");

  mask_compare_a : assert property (
    bus_cycle.valid && all_on && addr_miss |=> !q.hit)
    else $error("unmasked address bit differed but matched");

  match_req_a : assert property (
    hit_now && !q.ctrl[CTRL_DIS_BIT] |=> break_req && !match_trigger_out_n && q.stat[STAT_BREAK])
    else $error("match did not raise request and trigger together");

  disable_req_a : assert property (
    hit_now && q.ctrl[CTRL_DIS_BIT] |=> !break_req && !match_trigger_out_n)
    else $error("disabled break still requested");

  trig_four_a : assert property (
    q.hit && wid_sel == 2'h1 ##1 quiet4_s |-> match_trigger_out_n && !$past(match_trigger_out_n))
    else $error("trigger width for code 01 not four clocks");

  trig_one_a : assert property (
    q.hit && wid_sel == 2'h0 ##1 quiet1_s |-> match_trigger_out_n)
    else $error("trigger width for code 00 not one clock");

  fetch_byte_a : assert property (
    bus_cycle.valid && bus_cycle.is_fetch && size_sel == SZ_BYTE |=> !q.hit)
    else $error("fetch matched as byte access");

  src_cpu_a : assert property (
    bus_cycle.valid && !bus_cycle.is_dtc && src_sel == 2'h2 |=> !q.hit)
    else $error("CPU cycle matched a controller-only setting");

  kind_data_a : assert property (
    bus_cycle.valid && bus_cycle.is_fetch && kind_sel == 2'h2 |=> !q.hit)
    else $error("fetch matched a data-only setting");

  dir_read_a : assert property (
    bus_cycle.valid && bus_cycle.is_write && dir_sel == 2'h1 |=> !q.hit)
    else $error("write matched a read-only setting");

  rsvd_read_a : assert property (
    pready && !pwrite && paddr == OFS_CTRL |-> prdata[31:3] == 29'h0000_0000)
    else $error("reserved control bits read nonzero");

endmodule

// >>> hdl/ubc_pkg.sv
// Behaviour
// - Break address is two 16-bit R/W halves, high and low, reset to zero.
// - Address mask is two 16-bit R/W halves, one bit per address bit, reset zero.
// - Cycle source bits 7..6: 00 off, 01 CPU, 10 transfer controller, 11 both.
// - Fetch/access bits 5..4: 00 off, 01 fetch, 10 data, 11 both.
// - Direction bits 3..2: 00 off, 01 read, 10 write, 11 both.
// - Size bits 1..0: 00 any, 01 byte, 10 word, 11 longword.
// - Any of source, fetch/access or direction at 00 blocks every break.
// - Every instruction fetch counts as a word access, dual fetches too.
// - Matched size is the requested access size, not the bus width.
// - Reserved cycle bits 15..8 and control bits 15..3 read zero.
// - Control bits 2..1 set trigger width: 1, 4, 8 or 16 clocks.
// - Control bit 0 set suppresses break requests; clear allows them.
// - A match pulses the trigger and, with control bit 0 clear, raises the break request in the same cycle.
package ubc_pkg;

  localparam int unsigned ADDR_W = 8;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] OFS_BAR_HI   = 8'h00;
  localparam logic [7:0] OFS_BAR_LO   = 8'h04;
  localparam logic [7:0] OFS_MASK_HI  = 8'h08;
  localparam logic [7:0] OFS_MASK_LO  = 8'h0C;
  localparam logic [7:0] OFS_CYCLE    = 8'h10;
  localparam logic [7:0] OFS_CTRL     = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h1C;

  // ****************************************
  // Fields and encodings
  // ****************************************
  localparam int unsigned CYC_SRC_LSB  = 6;
  localparam int unsigned CYC_KIND_LSB = 4;
  localparam int unsigned CYC_DIR_LSB  = 2;
  localparam int unsigned CYC_SIZE_LSB = 0;
  localparam int unsigned CTRL_WID_LSB = 1;
  localparam int unsigned CTRL_DIS_BIT = 0;
  localparam int unsigned STAT_MATCH   = 0;
  localparam int unsigned STAT_BREAK   = 1;
  localparam logic [1:0]  SZ_ANY       = 2'h0;
  localparam logic [1:0]  SZ_BYTE      = 2'h1;
  localparam logic [1:0]  SZ_WORD      = 2'h2;
  localparam logic [1:0]  SZ_LONG      = 2'h3;
  localparam logic [4:0]  TRIG_W0      = 5'h01;
  localparam logic [4:0]  TRIG_W1      = 5'h04;
  localparam logic [4:0]  TRIG_W2      = 5'h08;
  localparam logic [4:0]  TRIG_W3      = 5'h10;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic        valid;
    logic        is_dtc;
    logic        is_fetch;
    logic        is_write;
    logic [1:0]  size;
    logic [31:0] addr;
  } ubc_cycle_s;

  typedef struct packed {
    logic [15:0] bar_hi;
    logic [15:0] bar_lo;
    logic [15:0] mask_hi;
    logic [15:0] mask_lo;
    logic [7:0]  cyc;
    logic [2:0]  ctrl;
    logic [1:0]  stat;
    logic [1:0]  imask;
    logic        hit;
    logic        req;
    logic        trig_n;
    logic        irq;
    logic [4:0]  trig_cnt;
    logic [31:0] rdata;
  } ubc_state_s;

  localparam ubc_state_s ST_RESET = '{trig_n: 1'b1, default: '0};

endpackage

// >>> test/ubc_bus_model.sv
module ubc_bus_model
  import ubc_pkg::*;
(
  input  wire logic                pclk,
  input  wire ubc_pkg::ubc_cycle_s req,
  output ubc_pkg::ubc_cycle_s      bus_cycle
);
  import ubc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  initial bus_cycle = '0;

  // Idle cycles churn every attribute so stale values never match
  always @(posedge pclk) begin
    if (req.valid) begin
      bus_cycle <= req;
    end else begin
      bus_cycle <= {1'b0, ~bus_cycle[36:0]};
    end
  end
endmodule

// >>> test/ubc_break_tb_top.sv
module ubc_break_tb_top;
  import ubc_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, break_req, trig_n, irq, e, hit;
  logic [7:0]  paddr, cyc;
  logic [31:0] pwdata, prdata, rd, bar, msk, d;
  logic [2:0]  ctl;
  ubc_cycle_s  req, bus_cycle, x;
  int          fails, num_checks, n;

  ubc_break u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_cycle(bus_cycle), .break_req(break_req), .match_trigger_out_n(trig_n), .irq(irq));
  ubc_bus_model u_bus (.pclk(pclk), .req(req), .bus_cycle(bus_cycle));

  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  function automatic logic exp_hit(logic [7:0] c, logic [31:0] b, logic [31:0] m, ubc_cycle_s y);
    logic [1:0] sz;
    sz = y.is_fetch ? SZ_WORD : y.size;
    return (y.is_dtc ? c[7] : c[6]) && (y.is_fetch ? c[4] : c[5]) && (y.is_write ? c[3] : c[2])
      && (c[1:0] == SZ_ANY || c[1:0] == sz) && (((y.addr ^ b) & ~m) == 32'h0);
  endfunction

  task automatic chk_reg(input logic [31:0] g, input logic [31:0] w);
    num_checks++;
    if (g !== w) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, w);
    end
  endtask

  task automatic chk_bit(input logic g, input logic w);
    chk_reg({31'h0, g}, {31'h0, w});
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    end
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #400000;
    fails++;
    report_and_stop();
  end

  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, req} = '0;
    fails = 0;
    num_checks = 0;
    void'($urandom(89));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk_reg(rd, 32'h0);
      d = $urandom;
      apb(1'b1, 8'(4 * i), d);
      apb(1'b0, 8'(4 * i), 32'h0);
      chk_reg(rd, i < 4 ? {16'h0, d[15:0]} : i == 4 ? {24'h0, d[7:0]} : {29'h0, d[2:0]});
    end
    apb(1'b1, 8'h24, 32'hFFFFFFFF);
    apb(1'b0, 8'h24, 32'h0);
    chk_reg(rd, 32'h0);
    chk_bit(e, 1'b1);
    repeat (60) begin
      bar = $urandom;
      msk = $urandom & $urandom & $urandom;
      cyc = 8'($urandom) | ($urandom_range(1) ? 8'hFC : 8'h00);
      ctl = 3'($urandom);
      if (cyc[5:4] == 2'b01) cyc[0] = 1'b0;
      x = ubc_cycle_s'({1'b1, 37'($urandom)});
      x.addr = $urandom_range(1) ? bar ^ ($urandom & msk) : $urandom;
      hit = exp_hit(cyc, bar, msk, x);
      apb(1'b1, OFS_BAR_HI, {16'h0, bar[31:16]});
      apb(1'b1, OFS_BAR_LO, {16'h0, bar[15:0]});
      apb(1'b1, OFS_MASK_HI, {16'h0, msk[31:16]});
      apb(1'b1, OFS_MASK_LO, {16'h0, msk[15:0]});
      apb(1'b1, OFS_CYCLE, {24'h0, cyc});
      apb(1'b1, OFS_CTRL, {29'h0, ctl});
      @(posedge pclk);
      req <= x;
      @(posedge pclk);
      req.valid <= 1'b0;
      @(posedge pclk);
      @(negedge pclk);
      chk_bit(break_req, hit & ~ctl[0]);
      n = 0;
      while (trig_n === 1'b0 && n < 20) begin
        n++;
        @(negedge pclk);
      end
      chk_reg(32'(n), !hit ? 0 : ctl[2:1] == 2'h0 ? 1 : 32'(4) << (ctl[2:1] - 1));
    end
    apb(1'b1, OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk_bit(rd[0], 1'b1);
    apb(1'b1, OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b1);
    apb(1'b1, OFS_IRQ_STAT, 32'h3);
    repeat (2) @(posedge pclk);
    chk_bit(irq, 1'b0);
    apb(1'b0, OFS_IRQ_STAT, 32'h0);
    chk_reg(rd, 32'h0);
    report_and_stop();
  end
endmodule
